// ---- verilog/sfcmd_top.sv ----
// Top of the flash command slice: link decoder plus system-clock timers and state.
// Assumes the serial host drives select, clock and data; status bits arrive on plain ports.
`timescale 1ns/10ps
`default_nettype none

module sfcmd_top #(
	parameter longint unsigned ERASE_CYCLES = sfcmd_pkg::ERASE_CYC,
	parameter longint unsigned PUW_CYCLES   = sfcmd_pkg::PUW_CYC
) (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	input  wire logic link_clk_i,
	input  wire logic select_n_i,
	input  wire logic serial_in_i,
	input  wire logic write_unlock_set_i,
	input  wire logic other_cycle_busy_i,
	input  wire logic protect_level_bit0_i,
	input  wire logic protect_level_bit1_i,
	output var  logic serial_out_o,
	output var  logic serial_out_en_o,
	output var  logic write_unlock_latch_o,
	output var  logic cycle_in_progress_flag_o,
	output var  logic array_erase_o,
	output var  logic deep_sleep_o,
	output var  logic write_inhibit_o
);
	import sfcmd_pkg::*;

	typedef struct packed {
		logic [2:0]  sel_sync;
		logic [1:0]  op_ok;
		logic [7:0]  op;
		logic        latch;
		logic        erasing;
		logic        erase_pulse;
		logic        sleep;
		logic        sleep_pend;
		logic        wake_busy;
		logic [31:0] tmr;
		logic [31:0] puw;
		logic        inhibit;
		logic        armed;
	} sfcmd_sys_t;

	sfcmd_sys_t   s_q, s_d;
	sfcmd_stat_t  stat_link;
	sfcmd_stat_t  stat_s1_q;
	sfcmd_stat_t  stat_s2_q;
	logic [7:0]   lk_op;
	logic         lk_done;
	logic         lk_dout;
	logic         lk_doe;
	logic         sel_rise;

	function automatic logic [31:0] cyc32(input longint unsigned v);
		cyc32 = (v < 1) ? 32'h00000001 : v[31:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Status carried to the link domain through two flip-flops on the link clock.
	always_comb begin
		stat_link.cycle_in_progress_flag = s_q.erasing | other_cycle_busy_i;
		stat_link.write_unlock_latch     = s_q.latch;
		stat_link.protect_level_bit1     = protect_level_bit1_i;
		stat_link.protect_level_bit0     = protect_level_bit0_i;
		stat_link.deep_sleep             = s_q.sleep | s_q.sleep_pend;
		stat_link.busy_wake              = s_q.wake_busy;
		stat_link.write_inhibit          = s_q.inhibit;
	end

	always_ff @(posedge link_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stat_s1_q <= '0;
			stat_s2_q <= '0;
		end else begin
			stat_s1_q <= stat_link;
			stat_s2_q <= stat_s1_q;
		end
	end

	sfcmd_link u_link (
		.sclk_i          (link_clk_i),
		.select_n_i      (select_n_i),
		.serial_in_i     (serial_in_i),
		.stat_i          (stat_s2_q),
		.last_op_o       (lk_op),
		.op_complete_o   (lk_done),
		.serial_out_o    (lk_dout),
		.serial_out_en_o (lk_doe)
	);

	////////////////////////////////////////////////////////////////////////////////
	// System-side control: the opcode word is stable while select is high, so it is
	// sampled only after the synchronised select has risen.
	assign sel_rise = s_q.sel_sync[1] & ~s_q.sel_sync[2];

	always_comb begin
		s_d             = s_q;
		s_d.sel_sync    = {s_q.sel_sync[1:0], select_n_i};
		s_d.op_ok       = {s_q.op_ok[0], lk_done};
		s_d.op          = lk_op;
		s_d.erase_pulse = 1'b0;
		// A frame arms the decoder once its completion mark is seen low, so a select pulse
		// without clocks cannot replay the previous opcode.
		if (!s_q.sel_sync[1] && !s_q.op_ok[1]) begin
			s_d.armed = 1'b1;
		end
		if (sel_rise) begin
			s_d.armed = 1'b0;
		end
		if (s_q.puw != 32'h00000000) begin
			s_d.puw = s_q.puw - 32'h00000001;
		end
		s_d.inhibit = (s_q.puw != 32'h00000000);
		if (write_unlock_set_i && !s_q.inhibit && !s_q.sleep) begin
			s_d.latch = 1'b1;
		end
		if (s_q.tmr != 32'h00000000) begin
			s_d.tmr = s_q.tmr - 32'h00000001;
		end
		if (s_q.tmr == 32'h00000001) begin
			if (s_q.erasing) begin
				s_d.erasing = 1'b0;
			end
			if (s_q.sleep_pend) begin
				s_d.sleep_pend = 1'b0;
				s_d.sleep      = 1'b1;
			end
			s_d.wake_busy = 1'b0;
		end
		if (sel_rise && s_q.armed && s_q.op_ok[1] && s_q.tmr == 32'h00000000) begin
			case (s_q.op)
				OP_WHOLE_ARRAY_ERASE: begin
					if (s_q.latch && !s_q.sleep && !other_cycle_busy_i
						&& !protect_level_bit0_i && !protect_level_bit1_i) begin
						s_d.erasing     = 1'b1;
						s_d.erase_pulse = 1'b1;
						s_d.latch       = 1'b0;
						s_d.tmr         = cyc32(ERASE_CYCLES);
					end
				end
				OP_DEEP_SLEEP: begin
					if (!s_q.sleep && !other_cycle_busy_i) begin
						s_d.sleep_pend = 1'b1;
						s_d.tmr        = cyc32(SLEEP_CYC);
					end
				end
				OP_WAKE_AND_ID: begin
					if (!other_cycle_busy_i && s_q.sleep) begin
						s_d.sleep     = 1'b0;
						s_d.wake_busy = 1'b1;
						s_d.tmr       = cyc32(WAKE1_CYC + WAKE2_CYC);
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q       <= '0;
			s_q.sel_sync <= 3'h7;
			s_q.puw   <= cyc32(PUW_CYCLES);
			s_q.inhibit <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		serial_out_o             = lk_dout;
		serial_out_en_o          = lk_doe;
		write_unlock_latch_o     = s_q.latch;
		cycle_in_progress_flag_o = s_q.erasing;
		array_erase_o            = s_q.erase_pulse;
		deep_sleep_o             = s_q.sleep;
		write_inhibit_o          = s_q.inhibit;
	end
endmodule : sfcmd_top // sfcmd_top
`default_nettype wire

// ---- verilog/sfcmd_pkg.sv ----
// Package for the flash command slice: opcodes, identity values and timer figures.
// Assumes a 50 MHz system clock and a serial link clock of its own.
package sfcmd_pkg;

	localparam int unsigned CLK_HZ = 50_000_000;

	// Opcodes.
	localparam logic [7:0] OP_WHOLE_ARRAY_ERASE = 8'hC7;
	localparam logic [7:0] OP_DEEP_SLEEP        = 8'hB9;
	localparam logic [7:0] OP_WAKE_AND_ID       = 8'hAB;
	localparam logic [7:0] OP_MFR_DEV_ID        = 8'h90;
	localparam logic [7:0] OP_THREE_BYTE_IDENT  = 8'h9F;
	localparam logic [7:0] OP_WRITE_UNLOCK      = 8'h06;

	// Identity values, arbitrary.
	localparam logic [7:0] MFR_ID_DEFAULT      = 8'h5A;
	localparam logic [7:0] DEVICE_ID_DEFAULT   = 8'h05;
	localparam logic [7:0] MEM_TYPE_DEFAULT    = 8'h20;
	localparam logic [7:0] CAPACITY_DEFAULT    = 8'h10;

	// Address values that select the first ID byte.
	localparam logic [23:0] ADDR_MFR_FIRST = 24'h000000;
	localparam logic [23:0] ADDR_DEV_FIRST = 24'h000001;

	// Bit counts within a frame.
	localparam logic [5:0] BITS_OPCODE = 6'h08;
	localparam logic [5:0] BITS_OP_ADDR = 6'h20;

	// Times in their own units, and cycles derived from them.
	localparam int unsigned ERASE_ALL_DURATION_MS  = 1000;
	localparam int unsigned SLEEP_ENTRY_DELAY_US   = 3;
	localparam int unsigned WAKE_DELAY_FIRST_US    = 3;
	localparam int unsigned WAKE_DELAY_SECOND_US   = 2;
	localparam int unsigned POWERUP_WRITE_DELAY_MS = 10;
	localparam longint unsigned ERASE_CYC   = longint'(ERASE_ALL_DURATION_MS) * CLK_HZ / 1000;
	localparam longint unsigned SLEEP_CYC   = (longint'(SLEEP_ENTRY_DELAY_US) * CLK_HZ + 999_999) / 1_000_000;
	localparam longint unsigned WAKE1_CYC   = (longint'(WAKE_DELAY_FIRST_US) * CLK_HZ + 999_999) / 1_000_000;
	localparam longint unsigned WAKE2_CYC   = (longint'(WAKE_DELAY_SECOND_US) * CLK_HZ + 999_999) / 1_000_000;
	localparam longint unsigned PUW_CYC     = longint'(POWERUP_WRITE_DELAY_MS) * CLK_HZ / 1000;

	// Link-side events carried to the system clock.
	typedef struct packed {
		logic erase_all;
		logic deep_sleep;
		logic wake;
	} sfcmd_evt_t;

	// Status and strap inputs seen by the link side.
	typedef struct packed {
		logic cycle_in_progress_flag;
		logic write_unlock_latch;
		logic protect_level_bit1;
		logic protect_level_bit0;
		logic deep_sleep;
		logic busy_wake;
		logic write_inhibit;
	} sfcmd_stat_t;

	typedef enum logic [6:0] {
		LK_OPCODE = 7'h01,
		LK_ADDR   = 7'h02,
		LK_DUMMY  = 7'h04,
		LK_OUT_ID = 7'h08,
		LK_OUT_MD = 7'h10,
		LK_OUT_3B = 7'h20,
		LK_IGNORE = 7'h40
	} sfcmd_link_st_t;

endpackage : sfcmd_pkg

// ---- verilog/sfcmd_link.sv ----
// Link-side command decoder clocked by the serial clock while selected.
// Assumes select_n_i is asynchronous reset of this domain; status arrives already synchronised.
`timescale 1ns/10ps
`default_nettype none
module sfcmd_link (
	input  wire logic                 sclk_i,
	input  wire logic                 select_n_i,
	input  wire logic                 serial_in_i,
	input  wire sfcmd_pkg::sfcmd_stat_t stat_i,
	output var  logic [7:0]           last_op_o,
	output var  logic                 op_complete_o,
	output var  logic                 serial_out_o,
	output var  logic                 serial_out_en_o
);
	import sfcmd_pkg::*;

	typedef struct packed {
		sfcmd_link_st_t st;
		logic [5:0]     cnt;
		logic [23:0]    sh;
		logic [23:0]    out;
		logic [7:0]     op;
		logic           done;
	} sfcmd_lk_t;

	// Opcode and completion mark that must outlive the frame for the system side.
	typedef struct packed {
		logic [7:0] op;
		logic       done;
	} sfcmd_lk_res_t;

	sfcmd_lk_t     s_q, s_d;
	sfcmd_lk_res_t r_q;
	logic          do_q;
	logic          oe_q;

	////////////////////////////////////////////////////////////////////////////////
	// Rising edge: shift in opcode and address, pick the output stream.
	always_comb begin
		s_d     = s_q;
		s_d.sh  = {s_q.sh[22:0], serial_in_i};
		s_d.cnt = s_q.cnt + 6'h01;
		s_d.done = 1'b0;
		case (s_q.st)
			LK_OPCODE: begin
				if (s_q.cnt == BITS_OPCODE - 6'h01) begin
					s_d.op   = s_d.sh[7:0];
					s_d.done = 1'b1;
					s_d.st   = LK_IGNORE;
					if (stat_i.busy_wake) begin
						s_d.st = LK_IGNORE;
					end else if (stat_i.deep_sleep && s_d.sh[7:0] != OP_WAKE_AND_ID) begin
						s_d.st = LK_IGNORE;
					end else if (s_d.sh[7:0] == OP_WAKE_AND_ID && !stat_i.cycle_in_progress_flag) begin
						s_d.st = LK_DUMMY;
					end else if (s_d.sh[7:0] == OP_MFR_DEV_ID && !stat_i.cycle_in_progress_flag) begin
						s_d.st = LK_ADDR;
					end else if (s_d.sh[7:0] == OP_THREE_BYTE_IDENT && !stat_i.cycle_in_progress_flag) begin
						s_d.st  = LK_OUT_3B;
						s_d.out = {MFR_ID_DEFAULT, MEM_TYPE_DEFAULT, CAPACITY_DEFAULT};
						s_d.cnt = 6'h00;
					end
				end
			end
			LK_DUMMY: begin
				s_d.done = 1'b0;
				if (s_q.cnt == BITS_OP_ADDR - 6'h01) begin
					s_d.st  = LK_OUT_ID;
					s_d.out = {DEVICE_ID_DEFAULT, 16'h0000};
				end
			end
			LK_ADDR: begin
				if (s_q.cnt == BITS_OP_ADDR - 6'h01) begin
					s_d.st  = LK_OUT_MD;
					s_d.out = (s_d.sh == ADDR_DEV_FIRST) ?
						{DEVICE_ID_DEFAULT, MFR_ID_DEFAULT, 8'h00} :
						{MFR_ID_DEFAULT, DEVICE_ID_DEFAULT, 8'h00};
					s_d.cnt = 6'h00;
				end
			end
			LK_OUT_ID: begin
				s_d.out = {s_q.out[22:16], s_q.out[23], 16'h0000};
			end
			LK_OUT_MD: begin
				s_d.out = {s_q.out[22:8], s_q.out[23], 8'h00};
			end
			LK_OUT_3B: begin
				s_d.out = {s_q.out[22:0], 1'b0};
			end
			LK_IGNORE: begin
				s_d.done = 1'b0;
			end
			default: begin
				s_d.st = LK_IGNORE;
			end
		endcase
	end

	always_ff @(posedge sclk_i or posedge select_n_i) begin
		if (select_n_i) begin
			s_q <= '{st: LK_OPCODE, cnt: 6'h00, sh: 24'h000000, out: 24'h000000, op: 8'h00, done: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// Kept out of the select reset, so the system clock can read them after select rises.
	always_ff @(posedge sclk_i) begin
		r_q <= '{op: s_d.op, done: s_d.done};
	end

	// Falling edge launches output bits MSB first.
	always_ff @(negedge sclk_i or posedge select_n_i) begin
		if (select_n_i) begin
			do_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			do_q <= s_q.out[23];
			oe_q <= (s_q.st == LK_OUT_ID) || (s_q.st == LK_OUT_MD) || (s_q.st == LK_OUT_3B);
		end
	end

	always_comb begin
		last_op_o       = r_q.op;
		op_complete_o   = r_q.done;
		serial_out_o    = do_q;
		serial_out_en_o = oe_q;
	end
endmodule : sfcmd_link // sfcmd_link
`default_nettype wire

// ---- verification/sfcmd_monitor.sv ----
// Checker for the ports of the flash command slice top.
// Assumes a bind onto sfcmd_top that hands on its two count parameters.
`timescale 1ns/10ps
`default_nettype none
module sfcmd_monitor #(
	parameter longint unsigned ERASE_CYCLES = 50,
	parameter longint unsigned PUW_CYCLES   = 20
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic link_clk_i,
	input wire logic select_n_i,
	input wire logic other_cycle_busy_i,
	input wire logic protect_level_bit0_i,
	input wire logic protect_level_bit1_i,
	input wire logic write_unlock_latch_o,
	input wire logic cycle_in_progress_flag_o,
	input wire logic array_erase_o,
	input wire logic deep_sleep_o,
	input wire logic write_inhibit_o
);
	logic [15:0] busy_q;
	logic [15:0] up_q;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_q <= 16'h0000;
			up_q   <= 16'h0000;
		end else begin
			busy_q <= cycle_in_progress_flag_o ? busy_q + 16'h0001 : 16'h0000;
			up_q   <= (up_q == 16'hFFFF) ? up_q : up_q + 16'h0001;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////////////////////////////////////////////
	erase_needs_latch_a: assert property ($rose(cycle_in_progress_flag_o) |-> $past(write_unlock_latch_o))
		else $error("erase started without unlock latch");
	erase_pulse_flag_a: assert property (array_erase_o |-> ##[0:1] cycle_in_progress_flag_o)
		else $error("array erase pulse without busy flag");
	erase_clears_latch_a: assert property ($rose(cycle_in_progress_flag_o) |-> !write_unlock_latch_o)
		else $error("unlock latch not cleared at erase start");
	erase_length_a: assert property ($fell(cycle_in_progress_flag_o)
		|-> busy_q + 2 >= ERASE_CYCLES && busy_q <= ERASE_CYCLES + 1)
		else $error("erase duration wrong");
	erase_protect_a: assert property ($rose(cycle_in_progress_flag_o)
		|-> $past(!protect_level_bit0_i && !protect_level_bit1_i))
		else $error("erase started with protect bits set");
	asleep_no_erase_a: assert property (deep_sleep_o |-> !array_erase_o)
		else $error("erase while asleep");
	sleep_not_busy_a: assert property ($rose(deep_sleep_o) |-> !cycle_in_progress_flag_o && !other_cycle_busy_i)
		else $error("sleep entered during a running cycle");
	reset_awake_a: assert property (!$past(resetn_i) |-> !deep_sleep_o)
		else $error("came out of reset asleep");
	inhibit_span_a: assert property (write_inhibit_o |-> up_q <= PUW_CYCLES + 2)
		else $error("write inhibit too long");
	inhibit_end_a: assert property ($fell(write_inhibit_o) |-> up_q + 2 >= PUW_CYCLES)
		else $error("write inhibit too short");
	latch_guard_a: assert property ($rose(write_unlock_latch_o) |-> !$past(deep_sleep_o) && !$past(write_inhibit_o))
		else $error("unlock latch set while asleep or inhibited");
	erase_seen_c: cover property ($rose(cycle_in_progress_flag_o));
	sleep_seen_c: cover property ($rose(deep_sleep_o));
	wake_seen_c: cover property ($fell(deep_sleep_o));
endmodule // sfcmd_monitor
`default_nettype wire

// ---- verification/sfcmd_host.sv ----
// SPI host model that frames commands for the flash command slice.
// Assumes the link clock idles low and stands still between frames.
`timescale 1ns/10ps
`default_nettype none
module sfcmd_host (
	input  wire logic sdi_i,
	output var  logic sclk_o,
	output var  logic select_n_o,
	output var  logic sdo_o
);
	initial begin
		sclk_o     = 1'b0;
		select_n_o = 1'b1;
		sdo_o      = 1'b0;
	end
	// Shifts n bits MSB first, then extra clocks, raises select and rests high.
	// The extra clocks read the answer on rising edges into got, last bit lowest.
	task automatic frame(input logic [31:0] bits, input int n, input int extra, output logic [23:0] got);
		got = 24'h000000;
		select_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			sdo_o = bits[i];
			#3 sclk_o = 1'b1;
			#3 sclk_o = 1'b0;
		end
		for (int i = 0; i < extra; i++) begin
			sdo_o = ~sdo_o;
			#3 sclk_o = 1'b1;
			got = {got[22:0], sdi_i};
			#3 sclk_o = 1'b0;
		end
		#3 select_n_o = 1'b1;
		sdo_o = ~sdo_o;
		#100;
	endtask
endmodule // sfcmd_host
`default_nettype wire

// ---- verification/sfcmd_top_tb.sv ----
// Self-checking bench for the flash command slice.
// Assumes the host model frames commands and the bench drives the system inputs.
`timescale 1ns/10ps
`default_nettype none
module sfcmd_top_tb;
	import sfcmd_pkg::*;
	localparam longint unsigned EC = 50;
	localparam longint unsigned PC = 20;
	logic clk_i, resetn_i, unl, obusy, p0, p1, en_seen;
	wire logic sclk, sel_n, sdi, sdo, sdo_en, latch, flag, erase, sleep, inhib;
	logic [23:0] rx;
	int bad_count, checks;
	sfcmd_host u_host (.sdi_i(sdo), .sclk_o(sclk), .select_n_o(sel_n), .sdo_o(sdi));
	sfcmd_top #(.ERASE_CYCLES(EC), .PUW_CYCLES(PC)) uut (.clk_i(clk_i), .resetn_i(resetn_i),
		.link_clk_i(sclk), .select_n_i(sel_n), .serial_in_i(sdi), .write_unlock_set_i(unl),
		.other_cycle_busy_i(obusy), .protect_level_bit0_i(p0), .protect_level_bit1_i(p1),
		.serial_out_o(sdo), .serial_out_en_o(sdo_en), .write_unlock_latch_o(latch),
		.cycle_in_progress_flag_o(flag), .array_erase_o(erase), .deep_sleep_o(sleep), .write_inhibit_o(inhib));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (sdo_en === 1'b1) en_seen <= 1'b1;
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic chk(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk24(input string what, input logic [23:0] exp, input logic [23:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Sends one frame, then realigns to the system clock before anything is compared.
	task automatic cmd(input logic [31:0] bits, input int n, input int extra);
		u_host.frame(bits, n, extra, rx);
		tick(1);
	endtask
	task automatic set_latch;
		unl = 1'b1;
		tick(1);
		unl = 1'b0;
		tick(1);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_power_up;
		chk("inhibit", 1'b1, inhib);
		chk("sleep", 1'b0, sleep);
		set_latch();
		chk("latch", 1'b0, latch);
		tick(int'(PC) + 4);
		chk("inhibit", 1'b0, inhib);
		$display("test power_up done");
	endtask
	task automatic t_erase_refused;
		cmd(OP_WHOLE_ARRAY_ERASE, 8, 0);
		chk("flag", 1'b0, flag);
		for (int k = 1; k < 4; k++) begin
			set_latch();
			{p1, p0} = k[1:0];
			cmd(OP_WHOLE_ARRAY_ERASE, 8, 0);
			chk("flag", 1'b0, flag);
		end
		{p1, p0} = 2'h0;
		cmd(OP_WHOLE_ARRAY_ERASE, 8, 1);
		chk("flag", 1'b0, flag);
		cmd(32'h00000063, 7, 0);
		chk("flag", 1'b0, flag);
		$display("test erase_refused done");
	endtask
	task automatic t_erase_run;
		int n;
		set_latch();
		cmd(OP_WHOLE_ARRAY_ERASE, 8, 0);
		chk("flag", 1'b1, flag);
		chk("latch", 1'b0, latch);
		en_seen = 1'b0;
		cmd(OP_DEEP_SLEEP, 8, 0);
		cmd(OP_THREE_BYTE_IDENT, 8, 24);
		chk24("id busy", 24'h000000, rx);
		cmd(OP_WAKE_AND_ID, 8, 0);
		chk("flag", 1'b1, flag);
		chk("id out", 1'b0, en_seen);
		n = 0;
		while (flag === 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		chk("flag", 1'b0, flag);
		chk("sleep", 1'b0, sleep);
		obusy = 1'b1;
		cmd(OP_DEEP_SLEEP, 8, 0);
		tick(int'(SLEEP_CYC) + 20);
		chk("sleep", 1'b0, sleep);
		obusy = 1'b0;
		$display("test erase_run done");
	endtask
	task automatic t_sleep;
		cmd(OP_DEEP_SLEEP, 8, 0);
		chk("sleep", 1'b0, sleep);
		tick(int'(SLEEP_CYC) + 20);
		chk("sleep", 1'b1, sleep);
		set_latch();
		chk("latch", 1'b0, latch);
		cmd(OP_WHOLE_ARRAY_ERASE, 8, 0);
		chk("flag", 1'b0, flag);
		cmd(OP_WAKE_AND_ID, 8, 0);
		chk("sleep", 1'b0, sleep);
		tick(int'(WAKE1_CYC + WAKE2_CYC) + 5);
		$display("test sleep done");
	endtask
	task automatic t_ident;
		logic [31:0] w[4];
		logic [23:0] e[4];
		int nb[4];
		w = '{32'h0000009F, 32'h90000001, 32'h90000000, 32'hAB000000};
		nb = '{8, 32, 32, 32};
		e = '{{MFR_ID_DEFAULT, MEM_TYPE_DEFAULT, CAPACITY_DEFAULT},
			{DEVICE_ID_DEFAULT, MFR_ID_DEFAULT, DEVICE_ID_DEFAULT},
			{MFR_ID_DEFAULT, DEVICE_ID_DEFAULT, MFR_ID_DEFAULT},
			{DEVICE_ID_DEFAULT, DEVICE_ID_DEFAULT, DEVICE_ID_DEFAULT}};
		for (int k = 0; k < 4; k++) begin
			en_seen = 1'b0;
			cmd(w[k], nb[k], 24);
			chk("id out", 1'b1, en_seen);
			chk24("id bits", e[k], rx);
			tick(4);
			chk("id out end", 1'b0, sdo_en);
		end
		cmd(OP_THREE_BYTE_IDENT, 8, 12);
		chk24("id cut", {12'h000, MFR_ID_DEFAULT, MEM_TYPE_DEFAULT[7:4]}, rx);
		tick(4);
		chk("id cut end", 1'b0, sdo_en);
		$display("test ident done");
	endtask
	initial begin
		#100000;
		bad_count++;
		$display("BAD watchdog expected done seen timeout");
		complete_run();
	end
	initial begin
		{resetn_i, unl, obusy, p0, p1, en_seen} = 6'h00;
		bad_count = 0;
		checks = 0;
		tick(6);
		resetn_i = 1'b1;
		t_power_up();
		t_erase_refused();
		t_erase_run();
		t_sleep();
		t_ident();
		complete_run();
	end
endmodule // sfcmd_top_tb
bind sfcmd_top sfcmd_monitor #(.ERASE_CYCLES(ERASE_CYCLES), .PUW_CYCLES(PUW_CYCLES)) u_mon (.clk_i(clk_i),
	.resetn_i(resetn_i), .link_clk_i(link_clk_i), .select_n_i(select_n_i), .other_cycle_busy_i(other_cycle_busy_i),
	.protect_level_bit0_i(protect_level_bit0_i), .protect_level_bit1_i(protect_level_bit1_i),
	.write_unlock_latch_o(write_unlock_latch_o), .cycle_in_progress_flag_o(cycle_in_progress_flag_o),
	.array_erase_o(array_erase_o), .deep_sleep_o(deep_sleep_o), .write_inhibit_o(write_inhibit_o));
`default_nettype wire
